// File: inc/acs_params.svh
// offsets, field positions, masks and timing constants of the conversion sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACS_ADDR_W        3
`define ACS_OFF_CONVERTER_CONTROL_A     3'h0
`define ACS_OFF_CONVERTER_CONTROL_B     3'h1
`define ACS_OFF_REFERENCE_CONTROL   3'h2
`define ACS_OFF_TRIGGER_EVENT_CONTROL    3'h3
`define ACS_OFF_PRESC     3'h4
`define ACS_OFF_IRQMODE   3'h5
`define ACS_OFF_IRQLVL    3'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_CONVERTER_CONTROL_A_EN      0
`define ACS_CONVERTER_CONTROL_A_FLUSH   1
`define ACS_CONVERTER_CONTROL_A_ST_LO   2
`define ACS_CONVERTER_CONTROL_A_ST_HI   5
`define ACS_CONVERTER_CONTROL_A_DMA_LO  6
`define ACS_CONVERTER_CONTROL_A_DMA_HI  7
`define ACS_CONVERTER_CONTROL_B_RES_LO  1
`define ACS_CONVERTER_CONTROL_B_RES_HI  2
`define ACS_CONVERTER_CONTROL_B_FREE    3
`define ACS_CONVERTER_CONTROL_B_SIGNED  4
`define ACS_REF_TEMP      0
`define ACS_REF_BGAP      1
`define ACS_REF_SEL_LO    4
`define ACS_REF_SEL_HI    5
`define ACS_EV_ACT_LO     0
`define ACS_EV_ACT_HI     2
`define ACS_EV_SEL_LO     3
`define ACS_EV_SEL_HI     5
`define ACS_EV_SWP_LO     6
`define ACS_EV_SWP_HI     7
`define ACS_PRESC_LO      0
`define ACS_PRESC_HI      2

// ----------------------------------------------------------------
// storable bits and reset values
// ----------------------------------------------------------------
`define ACS_CONVERTER_CONTROL_A_KEEP    8'hC1
`define ACS_CONVERTER_CONTROL_B_MASK    8'h1E
`define ACS_REF_MASK      8'h33
`define ACS_PRESC_MASK    8'h07
`define ACS_RST_BYTE      8'h00

// ----------------------------------------------------------------
// converter timing
// ----------------------------------------------------------------
`define ACS_DIV_BASE      10'h004
`define ACS_PIPE_DEPTH    7
`define ACS_LAST12        3'h6
`define ACS_LAST8         3'h4
`define ACS_LAST_EVLINE   4'h7

`endif

// File: inc/acs_pkg.sv
// encodings shared by the conversion sequencer files
package acs_pkg;

   typedef enum logic [2:0] {
      ACS_EV_NONE  = 3'h0,
      ACS_EV_CH0   = 3'h1,
      ACS_EV_CH01  = 3'h2,
      ACS_EV_CH012 = 3'h3,
      ACS_EV_CH4   = 3'h4,
      ACS_EV_SWEEP = 3'h5,
      ACS_EV_SYNC  = 3'h6,
      ACS_EV_RSVD  = 3'h7
   } acs_event_action_mode_t;

   typedef enum logic [1:0] {
      ACS_RES_12R  = 2'h0,
      ACS_RES_RSVD = 2'h1,
      ACS_RES_8R   = 2'h2,
      ACS_RES_12L  = 2'h3
   } acs_res_t;

   typedef enum logic [1:0] {
      ACS_DMA_OFF  = 2'h0,
      ACS_DMA_01   = 2'h1,
      ACS_DMA_012  = 2'h2,
      ACS_DMA_0123 = 2'h3
   } acs_combined_transfer_request_select_t;

   typedef enum logic [1:0] {
      ACS_IRQ_DONE  = 2'h0,
      ACS_IRQ_BELOW = 2'h1,
      ACS_IRQ_ABOVE = 2'h2,
      ACS_IRQ_RSVD  = 2'h3
   } acs_irqmode_t;

endpackage : acs_pkg

// File: design/acs_prescaler.sv
// converter clock prescaler with restart
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_prescaler
   import acs_pkg::*;
(
   input  wire logic       clock_i,    // peripheral clock
   input  wire logic       rstn_i,     // async reset, active low
   input  wire logic [2:0] div_sel_i,  // divide by 4 shl sel
   input  wire logic       restart_i,  // restart: tick on next cycle
   output logic            tick_o,     // one cycle per converter period
   output logic            phase_o     // high in first half of period
);
   logic [9:0] div_w;
   logic [8:0] cnt_q;
   logic [8:0] reload_w;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   // divisor doubles per code step from 4 up to 512
   assign div_w    = 10'(`ACS_DIV_BASE << div_sel_i);
   assign reload_w = 9'(div_w - 10'h001);
   assign tick_o   = (cnt_q == 9'h000);
   assign phase_o  = ({1'b0, cnt_q} >= (div_w >> 1));

   // count down; restart forces zero so the next cycle opens a period
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= 9'h000;
      end else if (restart_i) begin
         cnt_q <= 9'h000;
      end else if (tick_o) begin
         cnt_q <= reload_w;
      end else begin
         cnt_q <= 9'(cnt_q - 9'h001);
      end
   end

endmodule : acs_prescaler

// File: design/acs_sequencer.sv
// conversion sequencer: registers, start priority, flush, events, transfer requests
//
// Functional notes
// - pending channels in one converter period start lowest number first
// - writing a start bit launches one conversion on that channel
// - several start bits in one write sweep those channels, lowest first
// - a start bit clears itself once its conversion begins
// - flush discards conversions in flight and restarts the converter clock next edge
// - pending starts and interrupted sweeps survive a flush and then complete
// - synchronised event mode flushes, restarts clock, converts next peripheral cycle
// - per-channel transfer requests plus a combined request chosen by a two-bit field
// - per-channel transfer requests stay active whatever the combined selection
// - enable bit turns the converter on; cleared it stays off
// - mode bit picks unsigned when zero, signed with differential when one
// - free-running bit sweeps the configured channels again and again
// - resolution field picks 12-bit right, 8-bit right or 12-bit left
// - reference field picks 1.00 V, supply fraction, external port A or B
// - bandgap enable bit powers the bandgap for measurement
// - temperature reference bit enables the temperature reference
// - each channel flags interrupt and event on completion or compare side
// - each channel holds its own interrupt enable and level
// - sweep field selects channel 0, 0-1, 0-2 or 0-3
// - event base line n feeds channel 0, next lines next channels, up to line 7
// - event action picks none, one to four channel triggers, sweep, flushed sweep
// - prescaler code divides the peripheral clock by 4 up to 512
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_sequencer
   import acs_pkg::*;
(
   input  wire logic                   clock_i,       // peripheral clock, 250 MHz
   input  wire logic                   rstn_i,        // async reset, active low
   input  wire logic [`ACS_ADDR_W-1:0] addr_i,        // register offset
   input  wire logic [7:0]             wdata_i,       // write data
   input  wire logic                   we_i,          // write strobe
   input  wire logic                   re_i,          // read strobe
   output logic      [7:0]             rdata_o,       // read data, cycle after re_i
   input  wire logic [7:0]             ev_i,          // event network lines, pulses
   input  wire logic [3:0]             above_i,       // per channel: result above compare
   output logic                        enable_o,      // converter enabled
   output logic                        signed_o,      // signed conversion mode
   output logic [1:0]                  resolution_o,  // result resolution code
   output logic [1:0]                  ref_sel_o,     // reference source select
   output logic                        bandgap_o,     // bandgap power request
   output logic                        temperature_reference_enable_o,     // temperature reference enable
   output logic                        conv_clock_o,  // converter clock
   output logic                        conv_start_o,  // conversion start pulse
   output logic [1:0]                  conv_ch_o,     // channel of conv_start_o
   output logic                        flush_o,       // pipeline flush pulse
   output logic [3:0]                  done_o,        // conversion complete pulses
   output logic [3:0]                  dma_req_o,     // per-channel transfer requests
   output logic                        dma_comb_o,    // combined transfer request
   output logic [3:0]                  ch_irq_o,      // per-channel interrupt pulses
   output logic [7:0]                  ch_irq_lvl_o,  // per-channel interrupt levels
   output logic [3:0]                  ch_event_o     // per-channel event pulses
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0] converter_control_a_q;
   logic [7:0] converter_control_b_q;
   logic [7:0] reference_control_q;
   logic [7:0] trigger_event_control_q;
   logic [7:0] presc_q;
   logic [7:0] irqmode_q;
   logic [7:0] irqlvl_q;
   logic [3:0] pending_q;
   logic       flush_q;
   logic [`ACS_PIPE_DEPTH-1:0] pipe_v_q;
   logic [1:0] pipe_ch_q [0:`ACS_PIPE_DEPTH-1];
   logic       wr_converter_control_a;
   logic [3:0] wr_start;
   logic       tick;
   logic       phase;
   logic       start_fire;
   logic [3:0] start_oh;
   logic [1:0] start_ch;
   logic [3:0] sweep_mask;
   logic [3:0] ev_start;
   logic       sync_ev;
   logic       continuous_sweep_enable_load;
   logic [3:0] set_vec;
   logic [2:0] last_idx;
   logic       done_v;
   logic [3:0] done_oh;
   logic [3:0] dma_mask;
   logic [3:0] cmp_hit;
   acs_event_action_mode_t event_action_mode;
   logic [2:0] event_line_base_select;

   assign event_action_mode    = acs_event_action_mode_t'(trigger_event_control_q[`ACS_EV_ACT_HI:`ACS_EV_ACT_LO]);
   assign event_line_base_select    = trigger_event_control_q[`ACS_EV_SEL_HI:`ACS_EV_SEL_LO];
   assign wr_converter_control_a = we_i && (addr_i == `ACS_OFF_CONVERTER_CONTROL_A);
   assign wr_start = wr_converter_control_a ? wdata_i[`ACS_CONVERTER_CONTROL_A_ST_HI:`ACS_CONVERTER_CONTROL_A_ST_LO] : 4'h0;

   // ----------------------------------------------------------------
   // converter clock
   // ----------------------------------------------------------------
   // flush_q restarts the divider so the next cycle is a period start
   acs_prescaler u_presc (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .div_sel_i (presc_q[`ACS_PRESC_HI:`ACS_PRESC_LO]),
      .restart_i (flush_q),
      .tick_o    (tick),
      .phase_o   (phase)
   );

   // ----------------------------------------------------------------
   // event decode and sweep mask
   // ----------------------------------------------------------------
   // sweep of channel 0 up to the channel named by the sweep field
   always_comb begin
      case (trigger_event_control_q[`ACS_EV_SWP_HI:`ACS_EV_SWP_LO])
         2'h0:    sweep_mask = 4'h1;
         2'h1:    sweep_mask = 4'h3;
         2'h2:    sweep_mask = 4'h7;
         default: sweep_mask = 4'hF;
      endcase
   end

   // line base+k feeds channel k; lines past 7 do not exist
   always_comb begin
      ev_start = 4'h0;
      for (int k = 0; k < 4; k++) begin
         if ((event_action_mode >= ACS_EV_CH0) && (event_action_mode <= ACS_EV_CH4) && (3'(k) < event_action_mode)
             && ((4'(event_line_base_select) + 4'(k)) <= `ACS_LAST_EVLINE)) begin
            ev_start[k] = ev_i[3'(event_line_base_select + 3'(k))];
         end
      end
      if (event_action_mode == ACS_EV_SWEEP || event_action_mode == ACS_EV_SYNC) begin
         ev_start = ev_i[event_line_base_select] ? sweep_mask : 4'h0;
      end
   end

   assign sync_ev = (event_action_mode == ACS_EV_SYNC) && ev_i[event_line_base_select];

   // ----------------------------------------------------------------
   // start selection
   // ----------------------------------------------------------------
   // lowest-numbered pending channel wins the converter period
   always_comb begin
      start_ch = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (pending_q[i]) begin
            start_ch = 2'(i);
         end
      end
   end

   // no start in the flush cycle: the restarted period takes it instead
   assign start_fire   = tick && converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN] && !flush_q && (pending_q != 4'h0);
   assign start_oh     = start_fire ? (4'h1 << start_ch) : 4'h0;
   assign continuous_sweep_enable_load = converter_control_b_q[`ACS_CONVERTER_CONTROL_B_FREE] && converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN] && (pending_q == 4'h0);
   assign set_vec      = wr_start | ev_start | (continuous_sweep_enable_load ? sweep_mask : 4'h0);

   // set wins over the hardware clear; pending bits outlive a flush
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pending_q <= 4'h0;
      end else begin
         pending_q <= (pending_q & ~start_oh) | set_vec;
      end
   end

   // flush from software or from a synchronised event, one cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= (wr_converter_control_a && wdata_i[`ACS_CONVERTER_CONTROL_A_FLUSH]) || sync_ev;
      end
   end

   // ----------------------------------------------------------------
   // conversion pipeline
   // ----------------------------------------------------------------
   // latency 1 + res/2 converter periods; reserved code runs as 12-bit
   assign last_idx = (converter_control_b_q[`ACS_CONVERTER_CONTROL_B_RES_HI:`ACS_CONVERTER_CONTROL_B_RES_LO] == ACS_RES_8R) ? `ACS_LAST8 : `ACS_LAST12;
   assign done_v   = tick && !flush_q && pipe_v_q[last_idx];
   assign done_oh  = done_v ? (4'h1 << pipe_ch_q[last_idx]) : 4'h0;

   // flush or disable drops everything in flight
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pipe_v_q <= '0;
      end else if (flush_q || !converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN]) begin
         pipe_v_q <= '0;
      end else if (tick) begin
         pipe_v_q <= {pipe_v_q[`ACS_PIPE_DEPTH-2:0], start_fire};
      end
   end

   // channel numbers travel beside the valid bits
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < `ACS_PIPE_DEPTH; i++) begin
            pipe_ch_q[i] <= 2'h0;
         end
      end else if (tick) begin
         pipe_ch_q[0] <= start_ch;
         for (int i = 1; i < `ACS_PIPE_DEPTH; i++) begin
            pipe_ch_q[i] <= pipe_ch_q[i-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // completion, transfer requests, interrupts
   // ----------------------------------------------------------------
   always_comb begin
      case (acs_combined_transfer_request_select_t'(converter_control_a_q[`ACS_CONVERTER_CONTROL_A_DMA_HI:`ACS_CONVERTER_CONTROL_A_DMA_LO]))
         ACS_DMA_01:   dma_mask = 4'h3;
         ACS_DMA_012:  dma_mask = 4'h7;
         ACS_DMA_0123: dma_mask = 4'hF;
         default:      dma_mask = 4'h0;
      endcase
   end

   // compare side is judged per channel at completion
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         case (acs_irqmode_t'(irqmode_q[2*k +: 2]))
            ACS_IRQ_BELOW: cmp_hit[k] = done_oh[k] && !above_i[k];
            ACS_IRQ_ABOVE: cmp_hit[k] = done_oh[k] && above_i[k];
            default:       cmp_hit[k] = done_oh[k];
         endcase
      end
   end

   // all request outputs are registered one-cycle pulses
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_o     <= 4'h0;
         dma_req_o  <= 4'h0;
         dma_comb_o <= 1'b0;
         ch_event_o <= 4'h0;
         ch_irq_o   <= 4'h0;
      end else begin
         done_o     <= done_oh;
         dma_req_o  <= done_oh;
         dma_comb_o <= ((done_oh & dma_mask) != 4'h0);
         ch_event_o <= cmp_hit;
         for (int k = 0; k < 4; k++) begin
            ch_irq_o[k] <= cmp_hit[k] && (irqlvl_q[2*k +: 2] != 2'h0);
         end
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // flush and start bits are not stored here; reserved bits are masked
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         converter_control_a_q   <= `ACS_RST_BYTE;
         converter_control_b_q   <= `ACS_RST_BYTE;
         reference_control_q <= `ACS_RST_BYTE;
         trigger_event_control_q  <= `ACS_RST_BYTE;
         presc_q   <= `ACS_RST_BYTE;
         irqmode_q <= `ACS_RST_BYTE;
         irqlvl_q  <= `ACS_RST_BYTE;
      end else if (we_i) begin
         case (addr_i)
            `ACS_OFF_CONVERTER_CONTROL_A:   converter_control_a_q   <= wdata_i & `ACS_CONVERTER_CONTROL_A_KEEP;
            `ACS_OFF_CONVERTER_CONTROL_B:   converter_control_b_q   <= wdata_i & `ACS_CONVERTER_CONTROL_B_MASK;
            `ACS_OFF_REFERENCE_CONTROL: reference_control_q <= wdata_i & `ACS_REF_MASK;
            `ACS_OFF_TRIGGER_EVENT_CONTROL:  trigger_event_control_q  <= wdata_i;
            `ACS_OFF_PRESC:   presc_q   <= wdata_i & `ACS_PRESC_MASK;
            `ACS_OFF_IRQMODE: irqmode_q <= wdata_i;
            `ACS_OFF_IRQLVL:  irqlvl_q  <= wdata_i;
            default:          ;
         endcase
      end
   end

   // read data only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (re_i) begin
         case (addr_i)
            `ACS_OFF_CONVERTER_CONTROL_A:   rdata_o <= converter_control_a_q | {2'h0, pending_q, 2'h0};
            `ACS_OFF_CONVERTER_CONTROL_B:   rdata_o <= converter_control_b_q;
            `ACS_OFF_REFERENCE_CONTROL: rdata_o <= reference_control_q;
            `ACS_OFF_TRIGGER_EVENT_CONTROL:  rdata_o <= trigger_event_control_q;
            `ACS_OFF_PRESC:   rdata_o <= presc_q;
            `ACS_OFF_IRQMODE: rdata_o <= irqmode_q;
            `ACS_OFF_IRQLVL:  rdata_o <= irqlvl_q;
            default:          rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // analog core controls, straight from flops
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         enable_o     <= 1'b0;
         signed_o     <= 1'b0;
         resolution_o <= 2'h0;
         ref_sel_o    <= 2'h0;
         bandgap_o    <= 1'b0;
         temperature_reference_enable_o    <= 1'b0;
         ch_irq_lvl_o <= 8'h00;
         conv_clock_o <= 1'b0;
         conv_start_o <= 1'b0;
         conv_ch_o    <= 2'h0;
         flush_o      <= 1'b0;
      end else begin
         enable_o     <= converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN];
         signed_o     <= converter_control_b_q[`ACS_CONVERTER_CONTROL_B_SIGNED];
         resolution_o <= converter_control_b_q[`ACS_CONVERTER_CONTROL_B_RES_HI:`ACS_CONVERTER_CONTROL_B_RES_LO];
         ref_sel_o    <= reference_control_q[`ACS_REF_SEL_HI:`ACS_REF_SEL_LO];
         bandgap_o    <= reference_control_q[`ACS_REF_BGAP];
         temperature_reference_enable_o    <= reference_control_q[`ACS_REF_TEMP];
         ch_irq_lvl_o <= irqlvl_q;
         conv_clock_o <= phase && converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN];
         conv_start_o <= start_fire;
         conv_ch_o    <= start_ch;
         flush_o      <= flush_q;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence seq_flush_restart;
      flush_q ##1 tick;
   endsequence

   a_lowest_first: assert property (
      start_fire |-> ((pending_q & 4'(start_oh - 4'h1)) == 4'h0) && ((pending_q & start_oh) != 4'h0))
      else $error("start did not pick lowest pending channel");

   a_write_start: assert property (
      (wr_start != 4'h0) |=> ((pending_q & $past(wr_start)) == $past(wr_start)))
      else $error("written start bit not pending");

   a_sweep_drain: assert property (
      (pending_q == 4'h3 && start_fire && set_vec == 4'h0) |=> (pending_q == 4'h2))
      else $error("sweep did not take channel 0 first");

   a_start_clear: assert property (
      (start_fire && ((set_vec & start_oh) == 4'h0)) |=> ((pending_q & $past(start_oh)) == 4'h0))
      else $error("start bit not cleared on start");

   a_flush_restart: assert property (
      flush_q |-> ##1 (tick && (pipe_v_q == '0)))
      else $error("flush did not restart clock and drop pipeline");

   a_flush_keeps: assert property (
      flush_q |=> (($past(pending_q) & ~pending_q) == 4'h0))
      else $error("pending start lost across flush");

   a_sync_sweep: assert property (
      (sync_ev && converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN]) |=> seq_flush_restart ##0 start_fire)
      else $error("synchronised event did not convert after flush");

   a_dma_comb: assert property (
      (done_v && (converter_control_a_q[`ACS_CONVERTER_CONTROL_A_DMA_HI:`ACS_CONVERTER_CONTROL_A_DMA_LO] == ACS_DMA_0123)) |=> dma_comb_o)
      else $error("combined request missing");

   a_dma_per_ch: assert property (
      done_v |=> (dma_req_o == $past(done_oh)) && $onehot(dma_req_o))
      else $error("per-channel request missing");

   a_disabled_idle: assert property (
      !converter_control_a_q[`ACS_CONVERTER_CONTROL_A_EN] |-> !start_fire)
      else $error("conversion started while disabled");

   a_continuous_sweep_enable_reload: assert property (
      (continuous_sweep_enable_load && !start_fire) |=> ((pending_q & $past(sweep_mask)) == $past(sweep_mask)))
      else $error("free-running sweep not reloaded");

endmodule : acs_sequencer

// File: testbench/acs_ev_model.sv
// event network model driving the trigger lines
`timescale 1ns/1ps
module acs_ev_model (
   input  wire logic       clock_i, // peripheral clock
   output logic      [7:0] ev_o     // event lines
);
   initial ev_o = 8'h00;
   // idle gap first so flushing triggers never crowd a conversion
   task automatic pulse(input int line);
      repeat (40) @(posedge clock_i);
      ev_o <= 8'h01 << line;
      @(posedge clock_i);
      ev_o <= 8'h00;
   endtask : pulse
endmodule : acs_ev_model

// File: testbench/acs_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module acs_sequencer_tb_top;
   import acs_pkg::*;
   logic       clock_i, rstn_i, we_i, re_i, enable_o, signed_o, bandgap_o, temperature_reference_enable_o;
   logic       conv_clock_o, conv_start_o, flush_o, dma_comb_o;
   logic [2:0] addr_i;
   logic [7:0] wdata_i, rdata_o, ev_i, ch_irq_lvl_o;
   logic [3:0] above_i, done_o, dma_req_o, ch_irq_o, ch_event_o;
   logic [1:0] resolution_o, ref_sel_o, conv_ch_o;
   int         n_fail = 0;
   int         num_checks = 0;
   int         cyc = 0;
   acs_sequencer acs_sequencer_inst (.clock_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
      .ev_i, .above_i, .enable_o, .signed_o, .resolution_o, .ref_sel_o, .bandgap_o, .temperature_reference_enable_o,
      .conv_clock_o, .conv_start_o, .conv_ch_o, .flush_o, .done_o, .dma_req_o, .dma_comb_o,
      .ch_irq_o, .ch_irq_lvl_o, .ch_event_o);
   acs_ev_model acs_ev_model_inst (.clock_i(clock_i), .ev_o(ev_i));
   // 4 ns peripheral clock
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard, well above the longest scenario
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      we_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr
   // data is looked at only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      re_i <= 1'b0;
      #1 `CHK(rdata_o, e)
      @(posedge clock_i);
   endtask : rd
   // bounded wait for a pulse, looked at 1 ns after each edge, the calling edge too,
   // so a pulse launched by the edge the caller returned on is not missed
   task automatic wait_hi(ref logic s, input int lim);
      #1;
      for (int k = 0; k < lim; k++) begin
         if (s === 1'b1) break;
         @(posedge clock_i);
         #1;
      end
   endtask : wait_hi
   // realign to an edge afterwards so the next drive lands on a rising edge
   task automatic wait_start(input logic [1:0] ch);
      wait_hi(conv_start_o, 600);
      `CHK({conv_start_o, conv_ch_o}, {1'b1, ch})
      @(posedge clock_i);
   endtask : wait_start
   initial begin
      {rstn_i, we_i, re_i, addr_i, wdata_i, above_i} = '0;
      repeat (20) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      wr(3'h2, 8'hFF);
      rd(3'h2, 8'h33);
      `CHK({ref_sel_o, bandgap_o, temperature_reference_enable_o}, 4'hF)
      // calibration value load is software's job; no calibration store here
      wr(3'h1, 8'h16);
      // outputs follow the register one edge later; look after that edge settled
      @(posedge clock_i);
      `CHK({signed_o, resolution_o}, 3'h7)
      wr(3'h1, 8'h00);
      // start ch1 and ch2 together, combined request on all channels
      wr(3'h0, 8'hD9);
      wait_start(2'h1);
      `CHK(enable_o, 1'b1)
      wait_start(2'h2);
      rd(3'h0, 8'hC1);
      wait_hi(dma_comb_o, 200);
      `CHK({dma_comb_o, done_o, dma_req_o}, 9'h122)
      `CHK({ch_event_o, ch_irq_o}, 8'h20)
      @(posedge clock_i);
      // event line 3 as base, one channel trigger
      wr(3'h3, 8'h19);
      acs_ev_model_inst.pulse(3);
      wait_start(2'h0);
      // software flush while the channel 0 conversion is still in flight
      wr(3'h0, 8'h03);
      wait_hi(flush_o, 4);
      `CHK(flush_o, 1'b1)
      @(posedge clock_i);
      // flushed sweep of ch0 and ch1 from event line 0
      wr(3'h3, 8'h46);
      acs_ev_model_inst.pulse(0);
      wait_hi(flush_o, 4);
      `CHK(flush_o, 1'b1)
      @(posedge clock_i);
      wait_start(2'h0);
      wait_start(2'h1);
      // free running sweep repeats without triggers
      wr(3'h3, 8'h40);
      wr(3'h1, 8'h08);
      wait_start(2'h0);
      wait_start(2'h1);
      wait_start(2'h0);
      print_verdict();
   end
endmodule : acs_sequencer_tb_top
